// ---- flash_self_program_ctrl_tb.sv ----
// testbench: register access, unlock, erase, write and read of the controller
`timescale 1ns/1ns
module flash_self_program_ctrl_tb;
    localparam int PW = 32;
    localparam int OSC_HZ = 10000; // three slow ticks in the unlock window
    logic pclk, presetn, psel, penable, pwrite, slow_osc;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, prdata_n;
    logic pready, pslverr, flash_ack, cpu_halt;
    logic [15:0] flash_rdata;
    fspc_pkg::fspc_flash_req_t flash_req;
    logic [7:0] rd, rd_n;
    logic rd_err;
    int err_count = 0;
    int n_checks = 0;
    int cyc = 0;
    // full-width controller facing the flash model
    fspc_ctrl #(.ADDR_HIGH_BITS(8), .PAGE_WORDS(PW), .SLOW_OSC_HZ(OSC_HZ)) DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .slow_internal_osc(slow_osc), .flash_req(flash_req), .flash_ack(flash_ack),
        .flash_rdata(flash_rdata), .cpu_halt(cpu_halt));
    // narrow variant sharing the bus, only its read data is watched
    fspc_ctrl #(.ADDR_HIGH_BITS(7), .PAGE_WORDS(PW), .SLOW_OSC_HZ(OSC_HZ)) DUT_NARROW (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata_n), .pready(), .pslverr(),
        .slow_internal_osc(slow_osc), .flash_req(), .flash_ack(1'b0),
        .flash_rdata(16'h0000), .cpu_halt());
    fspc_flash_model #(.PAGE_WORDS(PW)) FLASH (
        .pclk(pclk), .presetn(presetn), .flash_req(flash_req), .flash_ack(flash_ack),
        .flash_rdata(flash_rdata));
    // system clock and free-running slow oscillator
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    initial begin
        slow_osc = 1'b0;
        forever #500 slow_osc = ~slow_osc;
    end
    task automatic end_of_test();
        $display("mismatches %0d, comparisons %0d", err_count, n_checks);
        if (err_count == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // hang guard
    always @(posedge pclk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            $display("BAD %0t: run timed out", $time);
            end_of_test();
        end
    end
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t: word %h expected %h", $time, got, exp);
        end
    endtask
    // one apb transfer, result taken at the edge where pready is seen
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata[7:0];
        rd_n = prdata_n[7:0];
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdx(input logic [7:0] a);
        apb(1'b0, a, 8'h00);
    endtask
    // halt during operation, start bits self-clear
    task automatic run_op();
        @(posedge pclk);
        chk8({7'h00, cpu_halt}, 8'h01);
        while (cpu_halt !== 1'b0) @(posedge pclk);
        rdx(fspc_pkg::OFF_CTRL);
        chk8(rd & 8'h05, 8'h00);
    endtask
    task automatic t_reset();
        for (int i = 0; i < 11; i++) begin
            rdx(fspc_pkg::OFF_STEP * 8'(i));
            chk8(rd, fspc_pkg::RST_BYTE);
        end
        rdx(8'h30);
        chk8({7'h00, rd_err}, 8'h01);
    endtask
    // data pairs and address high widths
    task automatic t_regs();
        for (int i = 5; i < 11; i++) wr(fspc_pkg::OFF_STEP * 8'(i), 8'ha0 + 8'(i));
        for (int i = 5; i < 11; i++) begin
            rdx(fspc_pkg::OFF_STEP * 8'(i));
            chk8(rd, 8'ha0 + 8'(i));
        end
        wr(fspc_pkg::OFF_ADDR_HIGH, 8'hff);
        rdx(fspc_pkg::OFF_ADDR_HIGH);
        chk8(rd, 8'hff);
        chk8(rd_n, 8'h7f);
    endtask
    // failed unlock by timeout and by wrong key
    task automatic t_unlock_fail();
        wr(fspc_pkg::OFF_CTRL, 8'h80);
        rdx(fspc_pkg::OFF_CTRL);
        chk8(rd & 8'h80, 8'h00);
        wr(fspc_pkg::OFF_CTRL, 8'h68);
        rdx(fspc_pkg::OFF_CTRL);
        chk8(rd & 8'h08, 8'h08);
        repeat (600) @(posedge pclk);
        rdx(fspc_pkg::OFF_CTRL);
        chk8(rd & 8'h88, 8'h00);
        wr(fspc_pkg::OFF_CTRL, 8'h68);
        wr(fspc_pkg::OFF_D1L, 8'h00);
        wr(fspc_pkg::OFF_D1H, 8'h05);
        rdx(fspc_pkg::OFF_CTRL);
        chk8(rd & 8'h88, 8'h00);
    endtask
    task automatic t_unlock_ok();
        wr(fspc_pkg::OFF_CTRL, 8'h68);
        for (int i = 0; i < 6; i++) begin
            wr(fspc_pkg::OFF_D1L + 8'(4 * i), fspc_pkg::KEY_SEQ[47 - 8 * i -: 8]);
        end
        rdx(fspc_pkg::OFF_CTRL);
        chk8(rd & 8'h88, 8'h80);
    endtask
    task automatic t_program();
        wr(fspc_pkg::OFF_ADDR_HIGH, 8'h01);
        wr(fspc_pkg::OFF_ADDR_LOW, 8'h22);
        wr(fspc_pkg::OFF_D0L, 8'h34);
        rdx(fspc_pkg::OFF_ADDR_LOW);
        chk8(rd, 8'h22);
        wr(fspc_pkg::OFF_D0H, 8'h12);
        wr(fspc_pkg::OFF_D0L, 8'h78);
        wr(fspc_pkg::OFF_D0H, 8'h56);
        rdx(fspc_pkg::OFF_ADDR_LOW);
        chk8(rd, 8'h24);
        wr(fspc_pkg::OFF_CTRL, 8'h94);
        run_op();
        chk16(FLASH.erase_addr, 16'h0120);
        chk16(FLASH.mem[16'h013f], fspc_pkg::ERASED_WORD);
        wr(fspc_pkg::OFF_D0L, 8'h00);
        wr(fspc_pkg::OFF_CTRL, 8'h84);
        run_op();
        chk16(FLASH.mem[16'h0124], fspc_pkg::ERASED_WORD);
        chk16(FLASH.mem[16'h0122], 16'h1234);
        chk16(FLASH.mem[16'h0123], 16'h5678);
        chk16(FLASH.mem[16'h0120], fspc_pkg::ERASED_WORD);
        chk8(8'(FLASH.n_write), 8'(PW));
        wr(fspc_pkg::OFF_ADDR_HIGH, 8'h01);
        wr(fspc_pkg::OFF_ADDR_LOW, 8'h22);
        wr(fspc_pkg::OFF_CTRL, 8'hb3);
        run_op();
        rdx(fspc_pkg::OFF_D0L);
        chk8(rd, 8'h34);
        rdx(fspc_pkg::OFF_D0H);
        chk8(rd, 8'h12);
    endtask
    task automatic t_revoke();
        wr(fspc_pkg::OFF_CTRL, 8'h00);
        rdx(fspc_pkg::OFF_CTRL);
        chk8(rd & 8'h80, 8'h00);
        wr(fspc_pkg::OFF_CTRL, 8'h80);
        rdx(fspc_pkg::OFF_CTRL);
        chk8(rd & 8'h80, 8'h00);
        // a start without permission must leave the array alone
        wr(fspc_pkg::OFF_CTRL, 8'h94);
        repeat (20) @(posedge pclk);
        rdx(fspc_pkg::OFF_STATUS);
        chk8(rd, 8'h00);
        chk8({7'h00, flash_req.valid}, 8'h00);
    endtask
    // reset, then the scenarios in order
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_regs();
        t_unlock_fail();
        t_unlock_ok();
        t_program();
        t_revoke();
        end_of_test();
    end
endmodule

// ---- fspc_ctrl.sv ----
// self-programming controller: apb registers, unlock key check, erase/write/read sequencer
//
// Design decisions made here: the register addresses and the APB slave port.
`timescale 1ns/1ns
module fspc_ctrl #(
    parameter int ADDR_HIGH_BITS = 8,
    parameter int PAGE_WORDS = 128,
    parameter int SLOW_OSC_HZ = 32000
) (
    input wire logic pclk, // system clock
    input wire logic presetn, // asynchronous reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped address
    input wire logic slow_internal_osc, // slow oscillator pin, unlock timer clock
    output fspc_pkg::fspc_flash_req_t flash_req, // request to the flash array
    input wire logic flash_ack, // flash array operation done pulse
    input wire logic [15:0] flash_rdata, // flash array read word
    output logic cpu_halt // stalls the core
);
    localparam int PAGE_BITS = $clog2(PAGE_WORDS);
    localparam int TIMEOUT_TICKS = (fspc_pkg::UNLOCK_TIMEOUT_US * SLOW_OSC_HZ)
        / fspc_pkg::US_PER_S;
    localparam logic [15:0] TMO_LIMIT = (TIMEOUT_TICKS < 1) ? 16'h0001 : 16'(TIMEOUT_TICKS);
    localparam logic [7:0] HI_MASK = 8'((9'h001 << ADDR_HIGH_BITS) - 9'h001);
    localparam logic [PAGE_BITS-1:0] LAST_IDX = PAGE_BITS'(PAGE_WORDS - 1);

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_UNLOCK = 3'b001,
        ST_ERASE = 3'b010,
        ST_WRITE = 3'b011,
        ST_READ = 3'b100
    } fspc_state_t;

    fspc_state_t state_r;
    logic wen_r, upe_r, wstart_r, rden_r, rstart_r;
    logic [2:0] mode_r;
    logic [15:0] addr_r;
    logic [7:0] dlo_r [4];
    logic [7:0] dhi_r [4];
    logic [15:0] wbuf_r [PAGE_WORDS];
    logic [PAGE_BITS-1:0] idx_r;
    logic [2:0] key_idx_r;
    logic [15:0] tmo_cnt_r;
    logic osc_s1_r, osc_s2_r, osc_s3_r, osc_lvl_r;
    logic osc_tick;
    logic [31:0] rdata_r;
    logic err_r;
    logic acc_wr;
    logic unlock_ok, unlock_fail, wdone, rdone;
    logic key_hit, key_good;
    logic [7:0] wbyte;
    logic [15:0] page_base;

    // true when this write access targets the given register
    function automatic logic wr_hit(input logic [7:0] off, input logic [7:0] a, input logic w);
        return w && (a == off);
    endfunction

    // expected key byte for a position of the sequence
    function automatic logic [7:0] key_byte(input logic [2:0] k);
        return fspc_pkg::KEY_SEQ[8'd47 - {k, 3'b000} -: 8];
    endfunction

    // apb: zero-wait answer, read data and error prepared in the setup cycle
    assign pready = 1'b1;
    assign prdata = rdata_r;
    assign pslverr = err_r;
    assign acc_wr = psel && penable && pwrite;
    assign wbyte = pwdata[7:0];

    // read mux and decode error, captured while in setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_r <= 32'h0000_0000;
            err_r <= 1'b0;
        end else if (psel && !penable) begin
            err_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            case (paddr)
                fspc_pkg::OFF_CTRL: begin
                    rdata_r[7:0] <= {wen_r, mode_r, upe_r, wstart_r, rden_r, rstart_r};
                end
                fspc_pkg::OFF_ADDR_LOW: rdata_r[7:0] <= addr_r[7:0];
                fspc_pkg::OFF_ADDR_HIGH: rdata_r[7:0] <= addr_r[15:8];
                fspc_pkg::OFF_D0L: rdata_r[7:0] <= dlo_r[0];
                fspc_pkg::OFF_D0H: rdata_r[7:0] <= dhi_r[0];
                fspc_pkg::OFF_D1L: rdata_r[7:0] <= dlo_r[1];
                fspc_pkg::OFF_D1H: rdata_r[7:0] <= dhi_r[1];
                fspc_pkg::OFF_D2L: rdata_r[7:0] <= dlo_r[2];
                fspc_pkg::OFF_D2H: rdata_r[7:0] <= dhi_r[2];
                fspc_pkg::OFF_D3L: rdata_r[7:0] <= dlo_r[3];
                fspc_pkg::OFF_D3H: rdata_r[7:0] <= dhi_r[3];
                fspc_pkg::OFF_STATUS: rdata_r[7:0] <= {5'h00, state_r};
                default: err_r <= 1'b1;
            endcase
        end
    end

    // slow oscillator pin: three-stage sync, a level counts once stages two and three agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_s1_r <= 1'b0;
            osc_s2_r <= 1'b0;
            osc_s3_r <= 1'b0;
            osc_lvl_r <= 1'b0;
        end else begin
            osc_s1_r <= slow_internal_osc;
            osc_s2_r <= osc_s1_r;
            osc_s3_r <= osc_s2_r;
            if (osc_s2_r == osc_s3_r) begin
                osc_lvl_r <= osc_s3_r;
            end
        end
    end
    assign osc_tick = osc_s2_r && osc_s3_r && !osc_lvl_r;

    // key checking: position k expects data pair register D1L + 4k
    assign key_hit = acc_wr && (paddr >= fspc_pkg::OFF_D1L) && (paddr <= fspc_pkg::OFF_D3H);
    assign key_good = (paddr == 8'(fspc_pkg::OFF_D1L + {key_idx_r, 2'b00}))
        && (wbyte == key_byte(key_idx_r));
    assign unlock_ok = (state_r == ST_UNLOCK) && key_hit && key_good
        && (key_idx_r == fspc_pkg::KEY_LAST);
    assign unlock_fail = (state_r == ST_UNLOCK) && !unlock_ok
        && ((key_hit && !key_good) || (tmo_cnt_r >= TMO_LIMIT));
    assign wdone = (state_r == ST_WRITE || state_r == ST_ERASE) && flash_ack
        && (state_r == ST_ERASE || idx_r == LAST_IDX);
    assign rdone = (state_r == ST_READ) && flash_ack;

    // control register: software writes, hardware clears; a software set wins, but wen is set only by unlock and software can only clear it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wen_r <= 1'b0;
            mode_r <= 3'b000;
            upe_r <= 1'b0;
            wstart_r <= 1'b0;
            rden_r <= 1'b0;
            rstart_r <= 1'b0;
        end else if (wr_hit(fspc_pkg::OFF_CTRL, paddr, acc_wr)) begin
            wen_r <= (wen_r && pwdata[fspc_pkg::CB_WEN]) || unlock_ok;
            mode_r <= pwdata[fspc_pkg::CB_MODE_HI:fspc_pkg::CB_MODE_LO];
            upe_r <= pwdata[fspc_pkg::CB_UPE];
            wstart_r <= (wstart_r && !wdone) || pwdata[fspc_pkg::CB_WSTART];
            rden_r <= pwdata[fspc_pkg::CB_RDEN];
            rstart_r <= (rstart_r && !rdone) || pwdata[fspc_pkg::CB_RSTART];
        end else begin
            wen_r <= wen_r || unlock_ok;
            upe_r <= upe_r && !(unlock_ok || unlock_fail);
            wstart_r <= wstart_r && !wdone;
            rstart_r <= rstart_r && !rdone;
        end
    end

    assign cpu_halt = wstart_r || rstart_r;

    // address pair with variant masking of the high byte
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_r <= fspc_pkg::RST_ADDR;
        end else if (wr_hit(fspc_pkg::OFF_ADDR_LOW, paddr, acc_wr)) begin
            addr_r[7:0] <= wbyte;
        end else if (wr_hit(fspc_pkg::OFF_ADDR_HIGH, paddr, acc_wr)) begin
            addr_r[15:8] <= wbyte & HI_MASK;
        end else if (wr_hit(fspc_pkg::OFF_D0H, paddr, acc_wr)) begin
            addr_r <= (addr_r + 16'h0001) & {HI_MASK, 8'hff};
        end
    end

    // data register pairs; a finished read lands in pair zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 4; i++) begin
                dlo_r[i] <= fspc_pkg::RST_BYTE;
                dhi_r[i] <= fspc_pkg::RST_BYTE;
            end
        end else if (rdone) begin
            dlo_r[0] <= flash_rdata[7:0];
            dhi_r[0] <= flash_rdata[15:8];
        end else if (acc_wr) begin
            for (int i = 0; i < 4; i++) begin
                if (paddr == 8'(fspc_pkg::OFF_D0L + 8'(2 * i) * fspc_pkg::OFF_STEP)) begin
                    dlo_r[i] <= wbyte;
                end
                if (paddr == 8'(fspc_pkg::OFF_D0H + 8'(2 * i) * fspc_pkg::OFF_STEP)) begin
                    dhi_r[i] <= wbyte;
                end
            end
        end
    end

    // write buffer: one page of words, erased value after reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < PAGE_WORDS; i++) begin
                wbuf_r[i] <= fspc_pkg::ERASED_WORD;
            end
        end else if (wr_hit(fspc_pkg::OFF_D0H, paddr, acc_wr)) begin
            // whole word loaded on high byte; low byte never loads
            wbuf_r[addr_r[PAGE_BITS-1:0]] <= {wbyte, dlo_r[0]};
        end
    end

    // page base keeps high byte and top low bits
    assign page_base = {addr_r[15:PAGE_BITS], {PAGE_BITS{1'b0}}};

    // sequencer: unlock window, erase, page write, single read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_IDLE;
            idx_r <= '0;
            key_idx_r <= 3'h0;
            tmo_cnt_r <= 16'h0000;
            flash_req <= '0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    idx_r <= '0;
                    key_idx_r <= 3'h0;
                    tmo_cnt_r <= 16'h0000;
                    if (wstart_r && mode_r == fspc_pkg::MODE_ERASE && wen_r) begin
                        state_r <= ST_ERASE;
                        flash_req <= '{1'b1, fspc_pkg::FOP_ERASE, page_base, 16'h0000};
                    end else if (wstart_r && mode_r == fspc_pkg::MODE_WRITE && wen_r) begin
                        state_r <= ST_WRITE;
                        flash_req <= '{1'b1, fspc_pkg::FOP_WRITE, page_base, wbuf_r[0]};
                    end else if (rstart_r && mode_r == fspc_pkg::MODE_READ && rden_r) begin
                        state_r <= ST_READ;
                        flash_req <= '{1'b1, fspc_pkg::FOP_READ, addr_r, 16'h0000};
                    end else if (upe_r && mode_r == fspc_pkg::MODE_UNLOCK) begin
                        state_r <= ST_UNLOCK;
                    end
                end
                ST_UNLOCK: begin
                    if (osc_tick && tmo_cnt_r < TMO_LIMIT) begin
                        tmo_cnt_r <= tmo_cnt_r + 16'h0001;
                    end
                    if (key_hit && key_good) begin
                        key_idx_r <= key_idx_r + 3'h1;
                    end
                    if (unlock_ok || unlock_fail || !upe_r
                        || mode_r != fspc_pkg::MODE_UNLOCK) begin
                        state_r <= ST_IDLE;
                    end
                end
                ST_ERASE, ST_READ: begin
                    if (flash_ack) begin
                        flash_req <= '0;
                        state_r <= ST_IDLE;
                    end
                end
                ST_WRITE: begin
                    // program every word of the page
                    if (flash_ack) begin
                        if (idx_r == LAST_IDX) begin
                            flash_req <= '0;
                            state_r <= ST_IDLE;
                        end else begin
                            idx_r <= idx_r + 1'b1;
                            flash_req.addr <= page_base | 16'(idx_r + 1'b1);
                            flash_req.wdata <= wbuf_r[idx_r + 1'b1];
                        end
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                    flash_req <= '0;
                end
            endcase
        end
    end

    // ---- checks ----
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_d0h_write;
        acc_wr && paddr == fspc_pkg::OFF_D0H;
    endsequence

    a_halt_follows_start: assert property (
        (state_r == ST_ERASE || state_r == ST_WRITE || state_r == ST_READ) |-> cpu_halt)
        else $error("core not halted during flash operation");

    a_top_bit_zero: assert property (
        ADDR_HIGH_BITS < 8 |-> addr_r[15] == 1'b0)
        else $error("unimplemented address bit set");

    a_low_no_load: assert property (
        acc_wr && paddr == fspc_pkg::OFF_D0L
        |=> $stable(addr_r) && $stable(wbuf_r[addr_r[PAGE_BITS-1:0]]))
        else $error("low data byte write moved address or buffer");

    a_high_loads_word: assert property (
        s_d0h_write |=> wbuf_r[$past(addr_r[PAGE_BITS-1:0])] == {$past(wbyte), $past(dlo_r[0])})
        else $error("buffer word not loaded");

    a_addr_increments: assert property (
        s_d0h_write |=> addr_r == (($past(addr_r) + 16'h0001) & {HI_MASK, 8'hff}))
        else $error("address not incremented");

    a_status_only_unlock: assert property (
        $rose(wen_r) |-> $past(unlock_ok))
        else $error("status set without unlock");

    a_fail_clears_enable: assert property (
        unlock_fail |=> !upe_r && state_r == ST_IDLE && wen_r == $past(wen_r))
        else $error("failed unlock left enable set");

    a_ok_sets_status: assert property (
        unlock_ok |=> wen_r && !upe_r)
        else $error("good key did not enable writing");

    a_modify_gated: assert property (
        state_r == ST_IDLE ##1 (state_r == ST_WRITE || state_r == ST_ERASE) |-> $past(wen_r))
        else $error("flash modified without status");

    a_write_done_clears: assert property (
        wdone && !wr_hit(fspc_pkg::OFF_CTRL, paddr, acc_wr) |=> !wstart_r ##1 state_r == ST_IDLE)
        else $error("write start not cleared");

    a_read_loads_pair: assert property (
        rdone && !wr_hit(fspc_pkg::OFF_CTRL, paddr, acc_wr)
        |=> {dhi_r[0], dlo_r[0]} == $past(flash_rdata) && !rstart_r)
        else $error("read word not loaded");

    a_erase_page_aligned: assert property (
        state_r == ST_ERASE |-> flash_req.valid && flash_req.op == fspc_pkg::FOP_ERASE
            && flash_req.addr[PAGE_BITS-1:0] == '0)
        else $error("erase request not on a page boundary");

    a_reserved_no_op: assert property (
        state_r == ST_IDLE && mode_r != fspc_pkg::MODE_WRITE && mode_r != fspc_pkg::MODE_ERASE
            && mode_r != fspc_pkg::MODE_READ |=> state_r == ST_IDLE || state_r == ST_UNLOCK)
        else $error("reserved mode started an operation");
endmodule

// ---- fspc_flash_model.sv ----
// flash array model: word memory answering controller requests
`timescale 1ns/1ns
module fspc_flash_model #(
    parameter int PAGE_WORDS = 32
) (
    input wire logic pclk, // system clock
    input wire logic presetn, // reset, active low
    input wire fspc_pkg::fspc_flash_req_t flash_req, // request from controller
    output logic flash_ack, // done pulse
    output logic [15:0] flash_rdata // read word
);
    logic [15:0] mem [0:65535];
    logic [2:0] cnt_r;
    logic slow_r;
    logic [15:0] page_base;
    logic [15:0] erase_addr;
    int n_write;
    // base of the page holding the request address
    assign page_base = flash_req.addr & ~16'(PAGE_WORDS - 1);
    // one request at a time, latency alternates between prompt and slow
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flash_ack <= 1'b0;
            flash_rdata <= 16'h0000;
            cnt_r <= 3'h0;
            slow_r <= 1'b0;
            erase_addr <= 16'h0000;
            n_write <= 0;
        end else begin
            flash_ack <= 1'b0;
            flash_rdata <= ~flash_rdata; // no stale word outside an answer
            if (flash_req.valid && !flash_ack) begin
                if (cnt_r == (slow_r ? 3'h4 : 3'h0)) begin
                    cnt_r <= 3'h0;
                    slow_r <= ~slow_r;
                    flash_ack <= 1'b1;
                    case (flash_req.op)
                        fspc_pkg::FOP_READ: flash_rdata <= mem[flash_req.addr];
                        fspc_pkg::FOP_WRITE: begin
                            mem[flash_req.addr] <= flash_req.wdata;
                            n_write <= n_write + 1;
                        end
                        fspc_pkg::FOP_ERASE: begin
                            erase_addr <= flash_req.addr;
                            for (int i = 0; i < PAGE_WORDS; i++) begin
                                mem[page_base + 16'(i)] <= 16'hffff;
                            end
                        end
                        default: flash_ack <= 1'b1;
                    endcase
                end else begin
                    cnt_r <= cnt_r + 3'h1;
                end
            end
        end
    end
endmodule

// ---- fspc_pkg.sv ----
// package: register map, field layout, modes and timing of the self-programming controller
package fspc_pkg;
    // register byte addresses on the apb bus
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_ADDR_LOW = 8'h04;
    localparam logic [7:0] OFF_ADDR_HIGH = 8'h08;
    localparam logic [7:0] OFF_D0L = 8'h0c;
    localparam logic [7:0] OFF_D0H = 8'h10;
    localparam logic [7:0] OFF_D1L = 8'h14;
    localparam logic [7:0] OFF_D1H = 8'h18;
    localparam logic [7:0] OFF_D2L = 8'h1c;
    localparam logic [7:0] OFF_D2H = 8'h20;
    localparam logic [7:0] OFF_D3L = 8'h24;
    localparam logic [7:0] OFF_D3H = 8'h28;
    localparam logic [7:0] OFF_STATUS = 8'h2c;
    localparam logic [7:0] OFF_STEP = 8'h04;
    // control register bit positions
    localparam int CB_WEN = 7;
    localparam int CB_MODE_HI = 6;
    localparam int CB_MODE_LO = 4;
    localparam int CB_UPE = 3;
    localparam int CB_WSTART = 2;
    localparam int CB_RDEN = 1;
    localparam int CB_RSTART = 0;
    // reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_ADDR = 16'h0000;
    localparam logic [15:0] ERASED_WORD = 16'hffff;
    // operation mode field codes
    typedef enum logic [2:0] {
        MODE_WRITE = 3'b000,
        MODE_ERASE = 3'b001,
        MODE_READ = 3'b011,
        MODE_UNLOCK = 3'b110
    } fspc_mode_t;
    // unlock key, first byte in the top lane
    localparam logic [47:0] KEY_SEQ = 48'h00_04_0d_09_c3_40;
    localparam logic [2:0] KEY_LAST = 3'h5;
    // unlock window
    localparam int UNLOCK_TIMEOUT_US = 300;
    localparam int US_PER_S = 1000000;
    // flash array operations
    typedef enum logic [1:0] {
        FOP_READ = 2'b00,
        FOP_WRITE = 2'b01,
        FOP_ERASE = 2'b10
    } fspc_fop_t;
    typedef struct packed {
        logic valid;
        fspc_fop_t op;
        logic [15:0] addr;
        logic [15:0] wdata;
    } fspc_flash_req_t;
endpackage
